/* File: rtl/qsr_pkg.sv */
// constants, field layout and types of the queue, status and ram block
// assumes a 100 MHz system clock and a 32-bit classic wishbone slave port
package qsr_pkg;

  // timing
  localparam int CLK_MHZ      = 100;
  localparam int SCK_HALF_NS  = 40;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int RAM_WAIT     = 1;

  // queue geometry
  localparam int QUEUE_DEPTH  = 16;
  localparam int XFER_MAX     = 16;

  // register byte addresses
  localparam logic [8:0] ADR_CTL1 = 9'h000;
  localparam logic [8:0] ADR_CTL2 = 9'h004;
  localparam logic [8:0] ADR_CTL3 = 9'h008;
  localparam logic [8:0] ADR_STAT = 9'h00C;
  localparam logic [8:0] ADR_PINS = 9'h010;
  localparam logic       ADR_RAM_BIT = 1'b1;

  // ram word index segments, index = address bits 5:2
  localparam logic [1:0] SEG_RX  = 2'h0;
  localparam logic [1:0] SEG_TX  = 2'h1;
  localparam logic [1:0] SEG_CMD = 2'h2;

  // queue_control_one fields
  localparam int CTL1_EN_BIT   = 0;
  localparam int CTL1_MASTER_SELECT_BIT = 1;
  localparam int CTL1_BITS_LSB = 4;
  // queue_control_two fields
  localparam int CTL2_DONE_IE  = 15;
  localparam int CTL2_WRAP     = 14;
  localparam int CTL2_WRAP_TARGET_SEL     = 13;
  localparam int CTL2_END_LSB  = 8;
  localparam int CTL2_NEW_LSB  = 0;
  // queue_control_three fields
  localparam int CTL3_LOOP     = 2;
  localparam int CTL3_HALT_FAULT_IRQ_EN     = 1;
  localparam int CTL3_HALT     = 0;
  // pin register fields
  localparam int PINS_DEF_LSB  = 0;
  localparam int PINS_DIR_BIT  = 4;

  // reset values
  localparam logic [3:0] PTR_RST  = 4'h0;
  localparam logic [3:0] PINS_RST = 4'h0;

  typedef struct packed {
    logic       keep_select;
    logic       bits_sel;
    logic       delay_after;
    logic       delay_sck;
    logic [3:0] pcs;
  } qsr_cmd_t;

  typedef struct packed {
    logic       queue_done_flag;
    logic       master_conflict_flag;
    logic       halt_ack_flag;
    logic       unused;
    logic [3:0] completed_ptr;
  } qsr_status_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_XFER  = 3'b010,
    ST_STORE = 3'b011,
    ST_HALT  = 3'b100
  } qsr_state_t;

  // bits in one transfer: 8, or the programmed count (0 means 16)
  function automatic logic [4:0] qsr_nbits(input logic sel,
                                           input logic [3:0] bits);
    if (!sel)
      return 5'h08;
    else if (bits == 4'h0)
      return 5'h10;
    else
      return {1'b0, bits};
  endfunction

endpackage

/* File: rtl/qsr_shift.sv */
// serial shifter: msb first, clock idles low, samples on rising edge
// assumes a start pulse with transmit data and bit count held that cycle
`timescale 1ns/1ps
module qsr_shift import qsr_pkg::*; #(
  parameter int W    = XFER_MAX,
  parameter int HALF = SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [4:0]   nbits,
  input  wire logic [W-1:0] tx,
  input  wire logic         loop,
  // results
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      rx,
  // serial side
  input  wire logic         miso,
  output logic              sck,
  output logic              mosi
);

  localparam logic [4:0] WIDTH = 5'(W);
  localparam logic [7:0] DIV_END = 8'(HALF - 1);

  logic [W-1:0] sh;
  logic [4:0]   left;
  logic [7:0]   div;
  logic         samp;

  assign mosi = sh[W-1];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
      sh   <= '0;
      rx   <= '0;
      left <= 5'h0;
      div  <= 8'h00;
      sck  <= 1'b0;
      samp <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        sck  <= 1'b0;
      end else if (start && !busy) begin
        busy <= 1'b1;
        sh   <= tx << (WIDTH - nbits);
        rx   <= '0;
        left <= nbits;
        div  <= 8'h00;
        sck  <= 1'b0;
      end else if (busy) begin
        if (div == DIV_END) begin
          div <= 8'h00;
          sck <= ~sck;
          if (!sck) begin
            samp <= loop ? sh[W-1] : miso;
          end else begin
            sh   <= {sh[W-2:0], 1'b0};
            rx   <= {rx[W-2:0], samp};
            left <= left - 5'h1;
            if (left == 5'h1) begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end else begin
          div <= div + 8'h01;
        end
      end
    end
  end

endmodule // qsr_shift

/* File: rtl/qsr_top.sv */
// queue sequencer, control and status registers and shared queue ram
// assumes a classic wishbone master on CLK and async serial pins
`timescale 1ns/1ps
module qsr_top import qsr_pkg::*; #(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WAITS = RAM_WAIT
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // wishbone slave
  input  wire logic [8:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // interrupt request
  output logic             IRQ,
  // serial pins
  output logic             SCK,
  output logic             MOSI,
  input  wire logic        MISO,
  output logic      [3:1]  PCS_O,
  output logic             PCS0_O,
  output logic             PCS0_OE,
  input  wire logic        PCS0_I
);

  // registers
  logic        port_enable;
  logic        master_select;
  logic [3:0]  bits_count;
  logic        queue_done_irq_en;
  logic        wrap_on;
  logic        wrap_target_sel;
  logic [3:0]  queue_last_ptr;
  logic [3:0]  queue_start_ptr;
  logic        serializer_loopback;
  logic        halt_fault_irq_en;
  logic        halt_req;
  logic [3:0]  pin_default_data;
  logic        pin_direction;
  qsr_status_t stat;
  qsr_status_t seen;

  // queue ram
  logic [15:0] rx_mem  [DEPTH];
  logic [15:0] tx_mem  [DEPTH];
  qsr_cmd_t    cmd_mem [DEPTH];

  // sequencer
  qsr_state_t  state;
  logic [3:0]  ptr;
  qsr_cmd_t    cur_cmd;
  logic        cs_hold;
  logic [3:0]  hold_pcs;
  logic        eng_ram;

  // serial engine
  logic        sh_busy;
  logic        sh_done;
  logic [15:0] sh_rx;
  logic        miso_s1;
  logic        miso_s2;
  logic        ss_s1;
  logic        ss_s2;

  // bus decode
  logic        req;
  logic        ram_hit;
  logic        ram_ok;
  logic [2:0]  wait_cnt;
  logic        go;
  logic        wr;
  logic        rd;
  logic [1:0]  seg;
  logic [3:0]  idx;

  // sequencer decisions
  logic        conflict_evt;
  logic        is_last;
  logic [3:0]  wrap_ptr;
  logic [3:0]  next_ptr;
  logic        end_queue;
  logic        set_done;
  logic        set_halt;
  logic        hw_clr_halt;
  logic        hw_disable;
  logic        clr_done;
  logic        clr_conf;
  logic        clr_halt;

  assign req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign ram_hit = WB_ADR_I[8] == ADR_RAM_BIT;
  assign seg     = WB_ADR_I[7:6];
  assign idx     = WB_ADR_I[5:2];
  // ram waits while enabled; engine access cycles stall the cpu
  assign ram_ok  = !eng_ram &&
                   (wait_cnt >= (port_enable ? 3'(WAITS) : 3'h0));
  assign go      = req && (!ram_hit || ram_ok);
  assign wr      = go && WB_WE_I;
  assign rd      = go && !WB_WE_I;

  // pin inputs pass two flops first
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      ss_s1   <= 1'b1;
      ss_s2   <= 1'b1;
    end else begin
      miso_s1 <= MISO;
      miso_s2 <= miso_s1;
      ss_s1   <= PCS0_I;
      ss_s2   <= ss_s1;
    end
  end

  // mode fault only when select pin is an input
  assign conflict_evt = port_enable && master_select && !pin_direction &&
                        !ss_s2;

  assign is_last   = ptr == queue_last_ptr;
  assign wrap_ptr  = wrap_target_sel ? queue_start_ptr : PTR_RST;
  assign next_ptr  = is_last ? wrap_ptr : ptr + 4'h1;
  assign end_queue = is_last && !wrap_on;
  assign set_done  = (state == ST_STORE) && is_last;
  assign set_halt  = (state == ST_STORE) && halt_req;
  assign hw_clr_halt = (state == ST_HALT) && !halt_req &&
                       port_enable;
  assign hw_disable = conflict_evt ||
                      ((state == ST_STORE) && end_queue);

  // cpu clears a flag only after having read it set
  assign clr_done = wr && !ram_hit && WB_ADR_I == ADR_STAT && WB_SEL_I[0] &&
                    seen.queue_done_flag && !WB_DAT_I[7];
  assign clr_conf = wr && !ram_hit && WB_ADR_I == ADR_STAT && WB_SEL_I[0] &&
                    seen.master_conflict_flag && !WB_DAT_I[6];
  assign clr_halt = wr && !ram_hit && WB_ADR_I == ADR_STAT && WB_SEL_I[0] &&
                    seen.halt_ack_flag && !WB_DAT_I[5];

  // wait counter for ram accesses
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      wait_cnt <= 3'h0;
    else if (req && ram_hit && !go && wait_cnt < 3'h4)
      wait_cnt <= wait_cnt + 3'h1;
    else if (!req)
      wait_cnt <= 3'h0;
  end

  // bus answer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= go;
      WB_DAT_O <= 32'h0000_0000;
      if (rd && ram_hit) begin
        case (seg)
          SEG_RX:  WB_DAT_O <= {16'h0000, rx_mem[idx]};
          SEG_TX:  WB_DAT_O <= {16'h0000, tx_mem[idx]};
          SEG_CMD: WB_DAT_O <= {24'h00_0000, cmd_mem[idx]};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end else if (rd) begin
        case (WB_ADR_I)
          ADR_CTL1: WB_DAT_O <= {24'h00_0000, bits_count, 2'b00,
                                 master_select, port_enable};
          ADR_CTL2: WB_DAT_O <= {16'h0000, queue_done_irq_en, wrap_on,
                                 wrap_target_sel, 1'b0, queue_last_ptr,
                                 4'h0, queue_start_ptr};
          ADR_CTL3: WB_DAT_O <= {29'h0000_0000, serializer_loopback,
                                 halt_fault_irq_en, halt_req};
          ADR_STAT: WB_DAT_O <= {24'h00_0000, stat};
          ADR_PINS: WB_DAT_O <= {27'h000_0000, pin_direction,
                                 pin_default_data};
          default:  WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control registers; hardware clears enable on fault or queue end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      port_enable         <= 1'b0;
      master_select       <= 1'b0;
      bits_count          <= 4'h0;
      queue_done_irq_en   <= 1'b0;
      wrap_on             <= 1'b0;
      wrap_target_sel     <= 1'b0;
      queue_last_ptr      <= PTR_RST;
      queue_start_ptr     <= PTR_RST;
      serializer_loopback <= 1'b0;
      halt_fault_irq_en   <= 1'b0;
      halt_req            <= 1'b0;
      pin_default_data    <= PINS_RST;
      pin_direction       <= 1'b0;
    end else begin
      if (hw_disable)
        port_enable <= 1'b0;
      if (wr && !ram_hit) begin
        case (WB_ADR_I)
          ADR_CTL1: if (WB_SEL_I[0]) begin
            port_enable   <= WB_DAT_I[CTL1_EN_BIT];
            master_select <= WB_DAT_I[CTL1_MASTER_SELECT_BIT];
            bits_count    <= WB_DAT_I[CTL1_BITS_LSB +: 4];
          end
          ADR_CTL2: begin
            if (WB_SEL_I[0])
              queue_start_ptr <= WB_DAT_I[CTL2_NEW_LSB +: 4];
            if (WB_SEL_I[1]) begin
              queue_done_irq_en <= WB_DAT_I[CTL2_DONE_IE];
              wrap_on           <= WB_DAT_I[CTL2_WRAP];
              wrap_target_sel   <= WB_DAT_I[CTL2_WRAP_TARGET_SEL];
              queue_last_ptr    <= WB_DAT_I[CTL2_END_LSB +: 4];
            end
          end
          ADR_CTL3: if (WB_SEL_I[0]) begin
            serializer_loopback <= WB_DAT_I[CTL3_LOOP];
            halt_fault_irq_en   <= WB_DAT_I[CTL3_HALT_FAULT_IRQ_EN];
            halt_req            <= WB_DAT_I[CTL3_HALT];
          end
          ADR_PINS: if (WB_SEL_I[0]) begin
            pin_default_data <= WB_DAT_I[PINS_DEF_LSB +: 4];
            pin_direction    <= WB_DAT_I[PINS_DIR_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // status flags: hardware set wins over cpu clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat <= '0;
      seen <= '0;
    end else begin
      stat.queue_done_flag <= set_done ||
        (stat.queue_done_flag && !clr_done);
      stat.master_conflict_flag <= conflict_evt ||
        (stat.master_conflict_flag && !clr_conf);
      stat.halt_ack_flag <= set_halt ||
        (stat.halt_ack_flag && !clr_halt && !hw_clr_halt);
      if (state == ST_STORE)
        stat.completed_ptr <= ptr;
      if (rd && !ram_hit && WB_ADR_I == ADR_STAT)
        seen <= stat;
      else if (wr && !ram_hit && WB_ADR_I == ADR_STAT)
        seen <= '0;
    end
  end

  // one request line for every source
  assign IRQ = (stat.queue_done_flag && queue_done_irq_en) ||
               ((stat.halt_ack_flag || stat.master_conflict_flag) &&
                halt_fault_irq_en);

  // queue ram; cpu word access is one cycle, so never split
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < DEPTH; i++) begin
        rx_mem[i]  <= 16'h0000;
        tx_mem[i]  <= 16'h0000;
        cmd_mem[i] <= '0;
      end
    end else begin
      if (state == ST_STORE)
        rx_mem[ptr] <= sh_rx;
      if (wr && ram_hit) begin
        case (seg)
          SEG_RX: begin
            if (WB_SEL_I[0]) rx_mem[idx][7:0]  <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) rx_mem[idx][15:8] <= WB_DAT_I[15:8];
          end
          SEG_TX: begin
            if (WB_SEL_I[0]) tx_mem[idx][7:0]  <= WB_DAT_I[7:0];
            if (WB_SEL_I[1]) tx_mem[idx][15:8] <= WB_DAT_I[15:8];
          end
          SEG_CMD: if (WB_SEL_I[0]) cmd_mem[idx] <= WB_DAT_I[7:0];
          default: ;
        endcase
      end
    end
  end

  // queue sequencer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state   <= ST_IDLE;
      ptr     <= PTR_RST;
      cur_cmd <= '0;
      eng_ram <= 1'b0;
    end else begin
      eng_ram <= 1'b0;
      if (conflict_evt) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: if (port_enable && master_select) begin
            ptr     <= queue_start_ptr;
            eng_ram <= 1'b1;
            state   <= ST_LOAD;
          end
          ST_LOAD: begin
            cur_cmd <= cmd_mem[ptr];
            state   <= port_enable ? ST_XFER : ST_IDLE;
          end
          ST_XFER: if (sh_done) begin
            eng_ram <= 1'b1;
            state   <= ST_STORE;
          end
          ST_STORE: begin
            ptr <= next_ptr;
            if (end_queue || !port_enable)
              state <= ST_IDLE;
            else if (halt_req)
              state <= ST_HALT;
            else begin
              eng_ram <= 1'b1;
              state   <= ST_LOAD;
            end
          end
          ST_HALT: if (!port_enable) begin
            state <= ST_IDLE;
          end else if (!halt_req) begin
            eng_ram <= 1'b1;
            state   <= ST_LOAD;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // select hold after a continue command
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cs_hold  <= 1'b0;
      hold_pcs <= PINS_RST;
    end else if (conflict_evt || state == ST_IDLE) begin
      cs_hold <= 1'b0;
    end else if (state == ST_STORE) begin
      cs_hold  <= cur_cmd.keep_select && !end_queue;
      hold_pcs <= cur_cmd.pcs;
    end
  end

  // select pins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PCS_O  <= PINS_RST[3:1];
      PCS0_O <= PINS_RST[0];
    end else if (state == ST_XFER ||
                 (state == ST_STORE && cur_cmd.keep_select)) begin
      {PCS_O, PCS0_O} <= cur_cmd.pcs;
    end else if (cs_hold) begin
      {PCS_O, PCS0_O} <= hold_pcs;
    end else begin
      {PCS_O, PCS0_O} <= pin_default_data;
    end
  end

  assign PCS0_OE = pin_direction;

  qsr_shift #(
    .W    (XFER_MAX),
    .HALF (SCK_HALF_CYC)
  ) u_shift (
    .clk   (CLK),
    .rst_b (RST_B),
    .start (state == ST_LOAD && port_enable),
    .abort (conflict_evt),
    .nbits (qsr_nbits(cmd_mem[ptr].bits_sel, bits_count)),
    .tx    (tx_mem[ptr]),
    .loop  (serializer_loopback),
    .busy  (sh_busy),
    .done  (sh_done),
    .rx    (sh_rx),
    .miso  (miso_s2),
    .sck   (SCK),
    .mosi  (MOSI)
  );

endmodule // qsr_top

/* File: dv/qsr_monitor.sv */
// port checker for the queue, status and ram block
// assumes 100 MHz CLK and a four-cycle serial half period
`timescale 1ns/1ps
module qsr_monitor import qsr_pkg::*; (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // wishbone
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // serial pins
  input wire logic        SCK,
  input wire logic        MOSI,
  input wire logic [3:1]  PCS_O,
  input wire logic        PCS0_O,
  input wire logic        PCS0_OE,
  input wire logic        PCS0_I
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  ack_bound_a: assert property (
    $rose(WB_STB_I) |-> ##[1:4] WB_ACK_O)
    else $error("ack later than four cycles");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  sck_high_a: assert property ($rose(SCK) |-> SCK [*4] ##1 !SCK)
    else $error("serial clock high phase wrong");
  sck_low_a: assert property ($fell(SCK) |-> !SCK [*4])
    else $error("serial clock low phase short");
  mosi_hold_a: assert property (SCK && $past(SCK) |-> $stable(MOSI))
    else $error("data out moved while clock high");
  pcs_hold_a: assert property (
    SCK |-> $stable(PCS_O) && $stable(PCS0_O))
    else $error("selects moved during a transfer");
  fault_stop_a: assert property (
    (!PCS0_OE && !PCS0_I) [*6] |-> !$rose(SCK))
    else $error("transfer went on after select fault");
endmodule // qsr_monitor

bind qsr_top qsr_monitor qsr_monitor_inst (
  .CLK(CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .SCK(SCK), .MOSI(MOSI),
  .PCS_O(PCS_O), .PCS0_O(PCS0_O), .PCS0_OE(PCS0_OE), .PCS0_I(PCS0_I));

/* File: dv/qsr_spi_slave.sv */
// spi slave model on the serial side of the queue block
// assumes sel active high, msb first, data changed after sck falls
`timescale 1ns/1ps
module qsr_spi_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // serial side
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        sel,
  output logic             miso,
  // stimulus and capture
  input  wire logic        slow,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] word,
  output logic      [15:0] got
);
  logic       sck_q;
  logic       tgl;
  logic       fell;
  logic [4:0] idx;
  logic [4:0] idx_n;

  assign fell  = sel && !sck && sck_q;
  assign idx_n = !fell ? idx : (idx + 5'h1 == nbits) ? 5'h0 : idx + 5'h1;
  // slow answers one cycle after the falling edge
  assign miso  = !sel ? tgl : word[4'(nbits - 5'h1 - (slow ? idx : idx_n))];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q <= 1'h0;
      tgl   <= 1'h0;
      idx   <= 5'h0;
      got   <= 16'h0;
    end else begin
      sck_q <= sck;
      tgl   <= ~tgl;
      idx   <= sel ? idx_n : 5'h0;
      if (sck && !sck_q)
        got <= {got[14:0], mosi};
    end
  end
endmodule // qsr_spi_slave

/* File: dv/tb.sv */
// self-checking bench for the queue, status and ram block
// assumes the slave model and the bound checker are compiled first
`timescale 1ns/1ps
module tb import qsr_pkg::*;;
  logic        clk, rst_b, we, cyc, stb, ack, irq, sck, mosi, miso;
  logic        pcs0, oe, pcs0_i, ext_ss, slow, want, note;
  logic [3:0]  bsel, lane;
  logic [3:1]  pcs;
  logic [4:0]  nbits;
  logic [8:0]  adr;
  logic [15:0] sword, got;
  logic [15:0] txw [16];
  logic [31:0] wdat, rdat, rv;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int          err_total, total_checks, cycles, seed, i;

  assign pcs0_i = oe ? pcs0 : ext_ss;

  qsr_top qsr_top_inst (
    .CLK(clk), .RST_B(rst_b), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(bsel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .SCK(sck), .MOSI(mosi),
    .MISO(miso), .PCS_O(pcs), .PCS0_O(pcs0), .PCS0_OE(oe),
    .PCS0_I(pcs0_i));
  qsr_spi_slave qsr_spi_slave_inst (
    .clk(clk), .rst_b(rst_b), .sck(sck), .mosi(mosi), .sel(pcs[1]),
    .miso(miso), .slow(slow), .nbits(nbits), .word(sword), .got(got));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    $display("mismatches %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    bsel <= lane;
    want <= note;
    note = 1'h0;
    do @(posedge clk); while (ack !== 1'h1);
    rv = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    note = 1'h1;
    wb(1'h0, a, 32'h0);
  endtask
  task automatic poll(input logic [31:0] m);
    rv = 32'h0;
    while ((rv & m) == 32'h0)
      wb(1'h0, ADR_STAT, 32'h0);
  endtask
  task automatic clr(input logic [31:0] e);
    rd(ADR_STAT, e, 32'h0000_00FF);
    wb(1'h1, ADR_STAT, 32'h0);
  endtask
  task automatic go(input logic [31:0] v);
    wb(1'h1, ADR_CTL1, 32'h0);
    wb(1'h1, ADR_CTL1, v);
  endtask
  function automatic logic [8:0] ra(input logic [1:0] s, input int n);
    return {1'h1, s, n[3:0], 2'h0};
  endfunction

  // read results checked against the oldest note
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      complete_run();
    end
    // only reads that left a note are compared
    if (ack === 1'h1 && we === 1'h0 && want === 1'h1 && exp_q.size() > 0)
      check($sformatf("read %h", adr), rdat & msk_q.pop_front(),
            exp_q.pop_front());
  end

  initial begin
    seed = 82149;
    {cyc, stb, we, slow} = 4'h0;
    {want, note} = 2'h0;
    {bsel, lane} = 8'hFF;
    adr = 9'h0;
    wdat = 32'h0;
    ext_ss = 1'h1;
    nbits = 5'h0C;
    sword = 16'($random(seed));
    rst_b = 1'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    rd(ADR_STAT, 32'h0, 32'h0000_00FF);
    wb(1'h1, 9'h014, 32'hFFFF_FFFF);
    rd(9'h014, 32'h0, 32'hFFFF_FFFF);
    wb(1'h1, ADR_PINS, 32'h0000_0010);
    for (i = 0; i < 16; i++) begin
      txw[i] = 16'($random(seed));
      wb(1'h1, ra(SEG_RX, i), 32'h0000_FFFF);
      wb(1'h1, ra(SEG_TX, i), {16'h0, txw[i]});
      wb(1'h1, ra(SEG_CMD, i), 32'h0000_0042);
    end
    // three 12-bit entries, done interrupt on
    wb(1'h1, ADR_CTL2, 32'h0000_8200);
    go(32'h0000_00C3);
    poll(32'h0000_0080);
    check("irq", 32'(irq), 32'h1);
    for (i = 0; i < 3; i++) begin
      rd(ra(SEG_RX, i), {20'h0, sword[11:0]}, 32'hFFFF_FFFF);
      rd(ra(SEG_TX, i), {16'h0, txw[i]}, 32'hFFFF_FFFF);
    end
    check("mosi", 32'(got[11:0]), 32'(txw[2][11:0]));
    rd(ADR_STAT, 32'h0000_0082, 32'h0000_00FF);
    wb(1'h1, ADR_STAT, 32'h0000_00FF);
    clr(32'h0000_0082);
    rd(ADR_STAT, 32'h0000_0002, 32'h0000_00FF);
    check("irq", 32'(irq), 32'h0);
    // low byte lane only: upper receive byte keeps its value
    lane = 4'h1;
    wb(1'h1, ra(SEG_RX, 5), 32'h0000_1234);
    lane = 4'hF;
    rd(ra(SEG_RX, 5), 32'h0000_FF34, 32'hFFFF_FFFF);
    // loopback on a 16-bit entry
    sword = ~txw[3];
    nbits = 5'h10;
    wb(1'h1, ADR_CTL3, 32'h0000_0004);
    wb(1'h1, ADR_CTL2, 32'h0000_0303);
    go(32'h0000_0003);
    poll(32'h0000_0080);
    rd(ra(SEG_RX, 3), {16'h0, txw[3]}, 32'hFFFF_FFFF);
    clr(32'h0000_0083);
    // halt in mid queue, slow slave, selects kept
    slow = 1'h1;
    nbits = 5'h0C;
    for (i = 0; i < 8; i++)
      wb(1'h1, ra(SEG_CMD, i), 32'h0000_00C2);
    wb(1'h1, ADR_CTL3, 32'h0000_0002);
    wb(1'h1, ADR_CTL2, 32'h0000_0700);
    go(32'h0000_00C3);
    wb(1'h1, ADR_CTL3, 32'h0000_0003);
    poll(32'h0000_0020);
    check("irq", 32'(irq), 32'h1);
    check("pcs", 32'({pcs, pcs0}), 32'h2);
    repeat (20) @(posedge clk);
    check("sck", 32'(sck), 32'h0);
    rd(ADR_STAT, 32'h0000_0020, 32'h0000_00E0);
    rd(ADR_CTL1, 32'h1, 32'h1);
    wb(1'h1, ADR_CTL3, 32'h0000_0002);
    poll(32'h0000_0080);
    clr(32'h0000_0087);
    check("irq", 32'(irq), 32'h0);
    // halt during the only command
    wb(1'h1, ADR_CTL2, 32'h0);
    go(32'h0000_00C3);
    wb(1'h1, ADR_CTL3, 32'h0000_0001);
    poll(32'h0000_0080);
    rd(ADR_CTL1, 32'h0, 32'h1);
    clr(32'h0000_00A0);
    wb(1'h1, ADR_CTL3, 32'h0);
    // wrap to the start pointer, two passes
    // entry 0 must stay untouched while wrapping to entry 2
    wb(1'h1, ra(SEG_RX, 0), 32'h0000_FFFF);
    wb(1'h1, ADR_CTL2, 32'h0000_6302);
    go(32'h0000_00C3);
    repeat (2) begin
      poll(32'h0000_0080);
      clr(32'h0000_0083);
    end
    wb(1'h1, ADR_CTL3, 32'h0000_0001);
    poll(32'h0000_0020);
    rd(ra(SEG_RX, 0), 32'h0000_FFFF, 32'hFFFF_FFFF);
    wb(1'h1, ADR_CTL1, 32'h0);
    wb(1'h1, ADR_CTL3, 32'h0000_0002);
    wb(1'h0, ADR_STAT, 32'h0);
    wb(1'h1, ADR_STAT, 32'h0);
    // select input pulled low while master
    wb(1'h1, ADR_CTL2, 32'h0);
    wb(1'h1, ADR_PINS, 32'h0);
    ext_ss <= 1'h0;
    go(32'h0000_00C3);
    poll(32'h0000_0040);
    check("irq", 32'(irq), 32'h1);
    check("pcs", 32'({pcs, pcs0}), 32'h0);
    rd(ADR_CTL1, 32'h0, 32'h1);
    clr(32'h0000_0042);
    // select pin as output driving low: no fault
    wb(1'h1, ADR_PINS, 32'h0000_0010);
    go(32'h0000_00C3);
    poll(32'h0000_0080);
    rd(ADR_STAT, 32'h0000_0080, 32'h0000_00C0);
    complete_run();
  end
endmodule // tb
